// file: rtl/dpf_frontend.v
// demodulator front-end control: carrier gating, symbol timing, descrambler, eye outputs, registers
`timescale 1ns/10ps
// Functional notes
// - carrier fail high keeps demodulator idle, no samples processed
// - falling carrier fail widens the phase-locked loop for acquisition
// - during training the symbol-pair clock follows the envelope input
// - after training the envelope is ignored, timing from received phase
// - training-extend input low lengthens envelope timing interval
// - demodulator drives converter strobe and converter clock
// - descrambler enabled while descramble select is low and control bit DPF_CTRL_DESCR_N is clear
// - two serial eye outputs shifted out by the converter strobe
module dpf_frontend (
    // clock and reset
    input  wire        REF_CLK,
    input  wire        RESETN,
    // avalon-mm slave
    input  wire [3:0]  AVS_ADDRESS,
    input  wire        AVS_READ,
    input  wire        AVS_WRITE,
    input  wire [31:0] AVS_WRITEDATA,
    input  wire [3:0]  AVS_BYTEENABLE,
    output reg  [31:0] AVS_READDATA,
    output wire        AVS_WAITREQUEST,
    // analog front end
    input  wire        CARRIER_FAIL_N,
    input  wire        ENVELOPE,
    input  wire        TRAIN_EXTEND_N,
    input  wire        DESCRAMBLE_SELECT_N,
    input  wire        RX_PHASE,
    // converter
    output wire        CONV_SAMPLE_STROBE,
    output wire        CONV_CLK,
    input  wire        CONV_DATA,
    // demodulator outputs
    output reg         EYE_Q,
    output reg         EYE_I,
    output reg         RX_DATA,
    output reg         PLL_WIDE,
    output reg         SYM_CLK
);
`include "dpf_regs.vh"

////////////////////////////////////////////////////////////////////////////////
    reg         rst_s1_ff;
    reg         rst_s2_ff;
    wire        rst_n;

    always @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rst_s1_ff <= 1'b0;
            rst_s2_ff <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_s2_ff <= rst_s1_ff;
        end
    end
    assign rst_n = rst_s2_ff;

////////////////////////////////////////////////////////////////////////////////
    // carrier gating and acquisition
    reg         car_d_ff;
    reg         env_d_ff;
    reg         ph_d_ff;
    reg  [7:0]  acq_ff;
    reg  [15:0] train_cnt_ff;
    reg         training_ff;
    reg  [15:0] train_len_ff;
    reg  [7:0]  ctrl_ff;
    wire        enabled;
    wire        car_fall;
    wire        env_rise;
    wire        ph_edge;
    wire        run;
    wire        frame_tick;
    wire [6:0]  word;
    wire        word_vld;

    assign enabled  = !CARRIER_FAIL_N;
    assign car_fall = car_d_ff && !CARRIER_FAIL_N;
    assign env_rise = ENVELOPE && !env_d_ff;
    assign ph_edge  = RX_PHASE ^ ph_d_ff;
    assign run      = enabled;

    always @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            car_d_ff     <= 1'b1;
            env_d_ff     <= 1'b0;
            ph_d_ff      <= 1'b0;
            acq_ff       <= 8'h00;
            PLL_WIDE     <= 1'b0;
            training_ff  <= 1'b0;
            train_cnt_ff <= 16'h0000;
            SYM_CLK      <= 1'b0;
        end else begin
            car_d_ff <= CARRIER_FAIL_N;
            env_d_ff <= ENVELOPE;
            ph_d_ff  <= RX_PHASE;
            if (!enabled) begin
                // idle: no acquisition, no training, symbol clock held low
                PLL_WIDE     <= 1'b0;
                training_ff  <= 1'b0;
                train_cnt_ff <= 16'h0000;
                SYM_CLK      <= 1'b0;
            end else if (car_fall) begin
                PLL_WIDE     <= 1'b1;
                acq_ff       <= `DPF_ACQ_LEN;
                training_ff  <= 1'b1;
                train_cnt_ff <= 16'h0000;
            end else begin
                if (frame_tick && acq_ff != 8'h00) begin
                    acq_ff <= acq_ff - 8'h01;
                end
                if (acq_ff == 8'h00) begin
                    PLL_WIDE <= 1'b0;
                end
                if (training_ff) begin
                    SYM_CLK <= env_rise ? ~SYM_CLK : SYM_CLK;
                    if (env_rise && TRAIN_EXTEND_N) begin
                        train_cnt_ff <= train_cnt_ff + 16'h0001;
                    end
                    // extend input low freezes the count, holding training open
                    if (TRAIN_EXTEND_N && train_cnt_ff >= train_len_ff) begin
                        training_ff <= 1'b0;
                    end
                end else begin
                    SYM_CLK <= ph_edge ? ~SYM_CLK : SYM_CLK;
                end
            end
        end
    end

////////////////////////////////////////////////////////////////////////////////
    // converter sequencer
    dpf_conv_seq u_seq (
        .clk                   (REF_CLK),
        .rst_n                 (rst_n),
        .run                   (run),
        .conv_sample_strobe_ff (CONV_SAMPLE_STROBE),
        .conv_clk_ff           (CONV_CLK),
        .conv_data             (CONV_DATA),
        .word_ff               (word),
        .word_vld_ff           (word_vld),
        .frame_tick            (frame_tick)
    );

////////////////////////////////////////////////////////////////////////////////
    // descrambler and eye data
    reg  [8:0]  lfsr_ff;
    reg  [6:0]  last_word_ff;
    reg         sample_vld_ff;
    reg         strb_d_ff;
    reg         rd_done_ff;
    wire        descr_on;
    wire        raw_bit;
    wire        clr_vld;

    function lfsr_fb;
        input [8:0] s;
        begin
            lfsr_fb = s[4] ^ s[8];
        end
    endfunction

    assign descr_on = !DESCRAMBLE_SELECT_N && !ctrl_ff[`DPF_CTRL_DESCR_N];
    assign raw_bit  = word[6];
    assign clr_vld  = AVS_READ && rd_done_ff && (AVS_ADDRESS == `DPF_OFF_SAMPLE);

    always @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            lfsr_ff       <= 9'h000;
            RX_DATA       <= 1'b1;
            last_word_ff  <= 7'h00;
            sample_vld_ff <= 1'b0;
            strb_d_ff     <= 1'b1;
            EYE_Q         <= 1'b0;
            EYE_I         <= 1'b0;
        end else begin
            strb_d_ff <= CONV_SAMPLE_STROBE;
            if (word_vld && run) begin
                last_word_ff  <= word;
                sample_vld_ff <= 1'b1;
                // self-synchronising: received bit feeds the register either way
                lfsr_ff <= {lfsr_ff[7:0], raw_bit};
                RX_DATA <= descr_on ? (raw_bit ^ lfsr_fb(lfsr_ff)) : raw_bit;
            end else if (clr_vld) begin
                // reading the sample retires it; a word landing in that cycle keeps the flag
                sample_vld_ff <= 1'b0;
            end
            // eye bits change on strobe fall so the external registers see them settled
            if (strb_d_ff && !CONV_SAMPLE_STROBE) begin
                EYE_Q <= last_word_ff[6] ^ ctrl_ff[`DPF_CTRL_EYE_Q];
                EYE_I <= last_word_ff[5];
            end
        end
    end

////////////////////////////////////////////////////////////////////////////////
    // avalon-mm registers, one wait cycle on reads
    assign AVS_WAITREQUEST = AVS_READ && !rd_done_ff;

    always @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            rd_done_ff   <= 1'b0;
            AVS_READDATA <= 32'h00000000;
            ctrl_ff      <= `DPF_CTRL_RST;
            train_len_ff <= `DPF_TRAIN_RST;
        end else begin
            rd_done_ff <= AVS_READ && !rd_done_ff;
            if (AVS_READ && !rd_done_ff) begin
                case (AVS_ADDRESS)
                    `DPF_OFF_CTRL:   AVS_READDATA <= {24'h000000, ctrl_ff};
                    `DPF_OFF_STATUS: AVS_READDATA <= {28'h0000000, sample_vld_ff, PLL_WIDE,
                                                      training_ff, enabled};
                    `DPF_OFF_SAMPLE: AVS_READDATA <= {25'h0000000, last_word_ff};
                    `DPF_OFF_TRAIN:  AVS_READDATA <= {16'h0000, train_len_ff};
                    default:         AVS_READDATA <= 32'h00000000;
                endcase
            end
            if (AVS_WRITE) begin
                if (AVS_ADDRESS == `DPF_OFF_CTRL && AVS_BYTEENABLE[0]) begin
                    ctrl_ff <= {6'h00, AVS_WRITEDATA[1:0]};
                end
                if (AVS_ADDRESS == `DPF_OFF_TRAIN) begin
                    if (AVS_BYTEENABLE[0]) train_len_ff[7:0]  <= AVS_WRITEDATA[7:0];
                    if (AVS_BYTEENABLE[1]) train_len_ff[15:8] <= AVS_WRITEDATA[15:8];
                end
            end
        end
    end

endmodule

// file: rtl/dpf_regs.vh
// constants, register map and timing counts for the demodulator front-end control
`ifndef DPF_REGS_VH
`define DPF_REGS_VH
// register byte offsets
`define DPF_OFF_CTRL       4'h0
`define DPF_OFF_STATUS     4'h4
`define DPF_OFF_SAMPLE     4'h8
`define DPF_OFF_TRAIN      4'hc
// control fields
`define DPF_CTRL_DESCR_N   0
`define DPF_CTRL_EYE_Q     1
`define DPF_CTRL_RST       8'h01
// status fields
`define DPF_ST_ENABLED     0
`define DPF_ST_TRAINING    1
`define DPF_ST_ACQUIRE     2
`define DPF_ST_VALID       3
// training length in symbol-pair periods, reset value
`define DPF_TRAIN_RST      16'h0100
// converter bit clock: 460 kHz trial rate from the 50 MHz clock
`define DPF_CLK_HZ         50000000
`define DPF_CONV_HZ        460000
`define DPF_CONV_HALF      (`DPF_CLK_HZ / (2 * `DPF_CONV_HZ))
`define DPF_CONV_BITS      7
// bit clocks per conversion frame: strobe, seven trials, two gap
`define DPF_FRAME_LEN      10
// acquisition pulse length in frames
`define DPF_ACQ_LEN        8'h40
`endif

// file: rtl/dpf_conv_seq.v
// converter sequencer: bit clock, sample strobe and serial word capture
`timescale 1ns/10ps
module dpf_conv_seq (
    // clock and reset
    input  wire       clk,
    input  wire       rst_n,
    // control
    input  wire       run,
    // converter pins
    output reg        conv_sample_strobe_ff,
    output reg        conv_clk_ff,
    input  wire       conv_data,
    // captured word
    output reg  [6:0] word_ff,
    output reg        word_vld_ff,
    output wire       frame_tick
);
`include "dpf_regs.vh"

    reg  [6:0] div_ff;
    reg  [3:0] bit_ff;
    reg  [6:0] shf_ff;
    wire       half_tick;
    wire       rise_tick;

    // end counts kept 32 bits wide and cut on purpose where compared
    localparam [31:0] half_end  = `DPF_CONV_HALF - 1;
    localparam [31:0] frame_end = `DPF_FRAME_LEN - 1;

    assign half_tick  = (div_ff == half_end[6:0]);
    assign rise_tick  = half_tick && !conv_clk_ff;
    assign frame_tick = rise_tick && (bit_ff == 4'h0);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_ff                <= 7'h00;
            conv_clk_ff           <= 1'b0;
            bit_ff                <= 4'h0;
            shf_ff                <= 7'h00;
            word_ff               <= 7'h00;
            word_vld_ff           <= 1'b0;
            conv_sample_strobe_ff <= 1'b1;
        end else begin
            word_vld_ff <= 1'b0;
            if (!run) begin
                div_ff                <= 7'h00;
                conv_clk_ff           <= 1'b0;
                bit_ff                <= 4'h0;
                conv_sample_strobe_ff <= 1'b1;
            end else begin
                div_ff <= half_tick ? 7'h00 : div_ff + 7'h01;
                if (half_tick) begin
                    conv_clk_ff <= ~conv_clk_ff;
                end
                if (rise_tick) begin
                    bit_ff <= (bit_ff == frame_end[3:0]) ? 4'h0 : bit_ff + 4'h1;
                    // falling strobe makes the hold capture a sample
                    conv_sample_strobe_ff <= (bit_ff != 4'h0);
                    if (bit_ff >= 4'h2 && bit_ff <= 4'h8) begin
                        shf_ff <= {shf_ff[5:0], conv_data};
                    end
                    // word is accepted only after the seventh bit is in
                    if (bit_ff == 4'h9) begin
                        word_ff     <= shf_ff;
                        word_vld_ff <= 1'b1;
                    end
                end
            end
        end
    end

endmodule

// file: verif/dpf_frontend_chk.sv
// port checker for the demodulator front-end control
`timescale 1ns/10ps
module dpf_frontend_chk (
    // clock and reset
    input wire REF_CLK,
    input wire RESETN,
    // bus
    input wire AVS_READ,
    input wire AVS_WAITREQUEST,
    // front end and converter
    input wire CARRIER_FAIL_N,
    input wire ENVELOPE,
    input wire RX_PHASE,
    input wire CONV_SAMPLE_STROBE,
    input wire CONV_CLK,
    // demodulator outputs
    input wire EYE_Q,
    input wire EYE_I,
    input wire PLL_WIDE,
    input wire SYM_CLK
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);
    AST_READ_ONE_WAIT: assert property (AVS_READ && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("read waited too long");
    AST_IDLE_CLK: assert property (CARRIER_FAIL_N [*8] |-> !CONV_CLK && CONV_SAMPLE_STROBE)
        else $error("converter clocked while idle");
    AST_IDLE_PLL: assert property (CARRIER_FAIL_N [*8] |-> !PLL_WIDE)
        else $error("loop widened while idle");
    AST_ACQ_WIDEN: assert property ($fell(CARRIER_FAIL_N) |-> ##[1:8] PLL_WIDE)
        else $error("loop not widened on carrier");
    AST_STROBE_LOW: assert property ($fell(CONV_SAMPLE_STROBE) |-> !CONV_SAMPLE_STROBE [*8])
        else $error("strobe pulse too short");
    // strobe moves with a bit-clock rise, or when a lost carrier parks the sequencer
    AST_STROBE_ON_CLK: assert property ($changed(CONV_SAMPLE_STROBE) |->
        $rose(CONV_CLK) || $past(CARRIER_FAIL_N))
        else $error("strobe off bit clock");
    AST_EYE_ON_STROBE: assert property ($changed({EYE_Q, EYE_I}) |-> !CONV_SAMPLE_STROBE)
        else $error("eye moved outside strobe");
    AST_SYM_CAUSE: assert property ($changed(SYM_CLK) |-> $past(CARRIER_FAIL_N)
        || $past(ENVELOPE, 6) != ENVELOPE || $past(RX_PHASE, 6) != RX_PHASE)
        else $error("symbol clock moved without cause");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind dpf_frontend dpf_frontend_chk dpf_frontend_chk_inst (.REF_CLK(REF_CLK), .RESETN(RESETN),
    .AVS_READ(AVS_READ), .AVS_WAITREQUEST(AVS_WAITREQUEST), .CARRIER_FAIL_N(CARRIER_FAIL_N),
    .ENVELOPE(ENVELOPE), .RX_PHASE(RX_PHASE), .CONV_SAMPLE_STROBE(CONV_SAMPLE_STROBE),
    .CONV_CLK(CONV_CLK), .EYE_Q(EYE_Q), .EYE_I(EYE_I), .PLL_WIDE(PLL_WIDE), .SYM_CLK(SYM_CLK));

// file: verif/dpf_conv_model.sv
// converter model: sample-and-hold, successive approximation, serial word
`timescale 1ns/10ps
module dpf_conv_model (
    // converter pins
    input  wire       conv_sample_strobe,
    input  wire       conv_clk,
    output reg        conv_data,
    // analog side
    input  wire [6:0] held_level,
    output reg  [6:0] word
);
    integer   cnt = 9;
    integer   b;
    reg [6:0] t;
    initial conv_data = 1'b0;
    initial word = 7'h00;
    // act on the falling bit clock, half a bit away from the capture edge
    always @(negedge conv_clk) begin
        if (!conv_sample_strobe && cnt > 7) begin
            cnt = 0;
            word = 7'h00;
            for (b = 6; b >= 0; b = b - 1) begin
                t = word | (7'h01 << b);
                if (held_level < t) word = t;
            end
        end else
            cnt = cnt + 1;
        // msb first; outside the word the line is not driven, so it wanders
        if (cnt >= 1 && cnt <= 7) conv_data = word[7 - cnt];
        else conv_data = ~conv_data;
    end
endmodule

// file: verif/test_dpf_frontend.sv
// self-checking bench for the demodulator front-end control
`timescale 1ns/10ps
`include "dpf_regs.vh"
module test_dpf_frontend;
    reg         clk, resetn, rd, wr, cf_n, env, ext_n, dsel_n, phase;
    reg  [3:0]  addr;
    reg  [31:0] wdata, seed, rv;
    reg  [6:0]  level;
    reg  [15:0] tlen;
    reg         sym_q;
    reg         dbit, sbit;
    reg  [8:0]  scr;
    wire [31:0] rdata;
    wire        wreq, strobe, cclk, cdata, eye_q, eye_i, rx_data, pll, sym;
    wire [6:0]  mword;
    integer     bad_count, total_checks, base, k;
    integer     sym_cnt = 0;
    dpf_frontend dpf_frontend_inst (.REF_CLK(clk), .RESETN(resetn), .AVS_ADDRESS(addr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(wreq), .CARRIER_FAIL_N(cf_n), .ENVELOPE(env), .TRAIN_EXTEND_N(ext_n),
        .DESCRAMBLE_SELECT_N(dsel_n), .RX_PHASE(phase), .CONV_SAMPLE_STROBE(strobe), .CONV_CLK(cclk),
        .CONV_DATA(cdata), .EYE_Q(eye_q), .EYE_I(eye_i), .RX_DATA(rx_data), .PLL_WIDE(pll), .SYM_CLK(sym));
    dpf_conv_model dpf_conv_model_inst (.conv_sample_strobe(strobe), .conv_clk(cclk), .conv_data(cdata),
        .held_level(level), .word(mword));
    function [31:0] lfsr(input [31:0] x);
        lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function [31:0] st(input en, input tr, input aq);
        st = {29'h0, aq, tr, en};
    endfunction
    task check(input [31:0] s, input [31:0] e);
        begin
            total_checks = total_checks + 1;
            if (s !== e) begin
                bad_count = bad_count + 1;
                $display("BAD %0t seen %h expected %h", $time, s, e);
            end
        end
    endtask
    task bus_wr(input [3:0] a, input [31:0] d);
        begin
            @(posedge clk);
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
            @(posedge clk);
            while (wreq !== 1'b0) @(posedge clk);
            wr <= 1'b0;
        end
    endtask
    task rd_chk(input [3:0] a, input [31:0] m, input [31:0] e);
        begin
            @(posedge clk);
            addr <= a;
            rd <= 1'b1;
            @(posedge clk);
            while (wreq !== 1'b0) @(posedge clk);
            rv = rdata;
            rd <= 1'b0;
            check(rv & m, e);
        end
    endtask
    task env_rises(input integer n);
        repeat (n) begin
            @(posedge clk);
            env <= 1'b1;
            repeat (10) @(posedge clk);
            env <= 1'b0;
            repeat (10) @(posedge clk);
        end
    endtask
    task give_verdict;
        begin
            $display("checks %0d mismatches %0d", total_checks, bad_count);
            if (bad_count == 0 && total_checks > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        sym_q <= sym;
        if (sym !== sym_q) sym_cnt <= sym_cnt + 1;
    end
    initial begin
        repeat (60000) @(posedge clk);
        bad_count = bad_count + 1;
        give_verdict;
    end
    initial begin
        {resetn, rd, wr, env, phase, addr, wdata, level} = 0;
        {cf_n, ext_n, dsel_n} = 3'b111;
        {bad_count, total_checks} = 0;
        scr = 9'h1ff;
        seed = 32'h82b51306;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        rd_chk(`DPF_OFF_CTRL, 32'hff, 32'h01);
        rd_chk(`DPF_OFF_TRAIN, 32'hffff, 32'h0100);
        rd_chk(`DPF_OFF_STATUS, 32'h7, st(0, 0, 0));
        rd_chk(4'h2, 32'hffffffff, 32'h0);
        check(cclk, 1'b0);
        seed = lfsr(seed);
        tlen = {14'h0, seed[1:0]} + 16'h2;
        bus_wr(`DPF_OFF_TRAIN, {16'h0, tlen});
        bus_wr(`DPF_OFF_CTRL, 32'h0);
        bus_wr(4'h2, seed);
        rd_chk(`DPF_OFF_TRAIN, 32'hffff, {16'h0, tlen});
        rd_chk(4'h2, 32'hffffffff, 32'h0);
        // carrier arrives while training is held open
        @(posedge clk);
        cf_n <= 1'b0;
        ext_n <= 1'b0;
        repeat (8) @(posedge clk);
        check(pll, 1'b1);
        rd_chk(`DPF_OFF_STATUS, 32'h7, st(1, 1, 1));
        base = sym_cnt;
        env_rises(tlen + 2);
        check(sym_cnt - base, tlen + 2);
        rd_chk(`DPF_OFF_STATUS, 32'h2, 32'h2);
        ext_n <= 1'b1;
        env_rises(tlen - 1);
        rd_chk(`DPF_OFF_STATUS, 32'h2, 32'h2);
        env_rises(1);
        rd_chk(`DPF_OFF_STATUS, 32'h2, 32'h0);
        base = sym_cnt;
        env_rises(3);
        check(sym_cnt - base, 0);
        repeat (2) begin
            @(posedge clk);
            phase <= ~phase;
            repeat (12) @(posedge clk);
        end
        check(sym_cnt - base, 2);
        // full scale, zero, then random held levels; descrambler off at the pin
        for (k = 0; k < 4; k = k + 1) begin
            @(negedge strobe);
            @(posedge clk);
            seed = lfsr(seed);
            level <= (k == 0) ? 7'h7f : (k == 1) ? 7'h00 : seed[6:0];
            @(negedge strobe);
            rd_chk(`DPF_OFF_STATUS, 32'h8, 32'h8);
            rd_chk(`DPF_OFF_SAMPLE, 32'h7f, {25'h0, mword});
            check(rx_data, mword[6]);
            rd_chk(`DPF_OFF_STATUS, 32'h8, 32'h0);
        end
        // scrambled line: word msb is set while the held level sits below half scale
        bus_wr(`DPF_OFF_CTRL, 32'h2);
        dsel_n <= 1'b0;
        for (k = 0; k < 16; k = k + 1) begin
            @(negedge strobe);
            @(posedge clk);
            // nine words in, the descrambler history matches the scrambler's
            if (k >= 10) check(rx_data, dbit);
            @(posedge clk);
            check(eye_q, !mword[6]);
            check(eye_i, mword[5]);
            seed = lfsr(seed);
            dbit = seed[0];
            sbit = dbit ^ scr[4] ^ scr[8];
            scr = {scr[7:0], sbit};
            level <= {~sbit, seed[6:1]};
        end
        // let the strobe stay low past the checker's eight-cycle minimum before the carrier goes
        repeat (12) @(posedge clk);
        cf_n <= 1'b1;
        repeat (20) @(posedge clk);
        check(cclk, 1'b0);
        rd_chk(`DPF_OFF_STATUS, 32'h1, 32'h0);
        give_verdict;
    end
endmodule
